// file: rtl/nip_map.svh
// Constant map for the nested interrupt priority controller
`ifndef NIP_MAP_SVH
`define NIP_MAP_SVH
`define NIP_PADDR_W        12
`define NIP_OFF_REQ        12'h000
`define NIP_OFF_MASK       12'h004
`define NIP_OFF_LEVEL      12'h008
`define NIP_OFF_STATUS     12'h00C
`define NIP_OFF_ACK        12'h010
`define NIP_ST_ACCEPT      1
`define NIP_ST_LEVEL       0
`define NIP_ST_INTRAP      2
`define NIP_ST_INMASK      3
`define NIP_RST_MASK       32'hFFFFFFFF
`define NIP_RST_LEVEL      32'hFFFFFFFF
`define NIP_RST_ACCEPT     1'b0
`define NIP_RST_INLEVEL    1'b1
`define NIP_HOLD_DONE      2'h2
`endif

// file: rtl/nip_pkg.sv
// Types for the nested interrupt priority controller
package nip_pkg;
   typedef enum logic [1:0] {
      NIP_OP_PLAIN,
      NIP_OP_HOLD,
      NIP_OP_TRAP
   } nip_opclass_t;
   typedef enum {
      NIP_GATE_OPEN,
      NIP_GATE_WAIT
   } nip_gate_t;
endpackage

// file: rtl/nip_ctrl.sv
// Nested interrupt acknowledge decision logic with APB register access
//
// How it works
// R1: No nesting while accept flag is clear
// R2: Any acknowledge clears the accept flag
// R3: Software re-enables acceptance inside service routine
// R4: Equal or higher priority nests when accepting
// R5: Lower priority never nests
// R6: Refused requests stay pending, flag kept
// R7: One program instruction runs after return
// R8: Level flag 0 admits only priority 0
// R9: Level flag 1 admits both levels
// R10: Trap routine admits both; trap always taken
// R11: Level bit 0 high, 1 low
// R12: Hold instruction defers past the next one
// R13: Hold class covers status and flag ops; APB hits on the flag registers defer, STATUS register accesses do not
// R14: Trap is not hold, but clears accept
// R15: Level bit never affects request flag setting
// R16: Acknowledge copies level bit into level flag
// R17: Eligible when request set and unmasked
// R18: Level first, lowest index breaks ties
// R19: Trap cannot be masked
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "nip_map.svh"
module nip_ctrl
   import nip_pkg::*;
#(
   parameter int NSRC = 32
) (
   // Clock and reset
   input  wire logic                   MCLK,
   input  wire logic                   SRST,
   // APB slave
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [`NIP_PADDR_W-1:0] PADDR,
   input  wire logic [31:0]            PWDATA,
   output logic      [31:0]            PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   // Interrupt sources, one-cycle set pulses
   input  wire logic [NSRC-1:0]        SRC_SET,
   // Sequencer
   input  wire logic                   INSTR_END,
   input  wire nip_opclass_t           INSTR_CLASS,
   input  wire logic                   OP_ENABLE,
   input  wire logic                   OP_MASK_ALL,
   input  wire logic                   OP_RET_IRQ,
   input  wire logic                   OP_RET_TRAP,
   input  wire logic                   RESTORE_VALID,
   input  wire logic [1:0]             RESTORE_STATUS,
   // Acknowledge outputs
   output logic                        ACK_VALID,
   output logic [$clog2(NSRC)-1:0]     ACK_ID,
   output logic                        ACK_TRAP,
   output logic [3:0]                  STATUS
);
   localparam int IW = $clog2(NSRC);

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   logic [NSRC-1:0] request_flag_r, request_flag_nxt;
   logic [NSRC-1:0] mask_flag_r, mask_flag_nxt;
   logic [NSRC-1:0] request_level_bit_r, request_level_bit_nxt;
   logic            global_irq_accept_flag_r, global_irq_accept_flag_nxt;
   logic            in_service_level_flag_r, in_service_level_flag_nxt;
   logic            in_trap_r, in_trap_nxt;
   logic            in_mask_r, in_mask_nxt;
   nip_gate_t       gate_r, gate_nxt;
   logic [1:0]      hold_cnt_r, hold_cnt_nxt;
   logic [31:0]     prdata_r, prdata_nxt;
   logic            ack_valid_r, ack_valid_nxt;
   logic [IW-1:0]   ack_id_r, ack_id_nxt;
   logic            ack_trap_r, ack_trap_nxt;

   // --------------------------------------------------------------
   // Priority pick
   // --------------------------------------------------------------
   function automatic logic [IW:0] pick(input logic [NSRC-1:0] cand);
      logic [IW:0] res;
      res = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (cand[i]) begin
            res = {1'b1, IW'(i)};
         end
      end
      return res;
   endfunction

   logic [NSRC-1:0] eligible;
   logic [NSRC-1:0] elig_hi;
   logic [IW:0]     pick_hi;
   logic [IW:0]     pick_any;
   logic [IW:0]     winner;
   logic            level_ok;
   logic            can_ack;
   logic            apb_wr;
   logic            apb_rd;
   logic            flag_reg_hit;

   always_comb begin
      eligible = request_flag_r & ~mask_flag_r;                       // [R17]
      elig_hi  = eligible & ~request_level_bit_r;                     // [R11]
      pick_hi  = pick(elig_hi);
      pick_any = pick(eligible);
      winner   = pick_hi[IW] ? pick_hi : pick_any;                    // [R18]
      // Trap routine or low-level service accepts both levels
      if (in_trap_r || in_service_level_flag_r) begin
         level_ok = winner[IW];                                       // [R9] [R10] [R4]
      end else begin
         level_ok = pick_hi[IW];                                      // [R8] [R5]
      end
      // Waiting for one instruction boundary blocks acknowledgement
      // A hold op's own end never acknowledges; the counter covers the end after it
      can_ack = global_irq_accept_flag_r && level_ok && gate_r == NIP_GATE_OPEN
                && hold_cnt_r == 2'h0 && INSTR_END && INSTR_CLASS != NIP_OP_HOLD; // [R1] [R12]
   end

   // --------------------------------------------------------------
   // APB decode
   // --------------------------------------------------------------
   always_comb begin
      apb_wr       = PSEL && PENABLE && PWRITE;
      apb_rd       = PSEL && !PENABLE && !PWRITE;
      flag_reg_hit = PSEL && PENABLE && (PADDR == `NIP_OFF_REQ || PADDR == `NIP_OFF_MASK
                     || PADDR == `NIP_OFF_LEVEL);
      PREADY       = 1'b1;
      PSLVERR      = PSEL && PENABLE && !(PADDR == `NIP_OFF_REQ || PADDR == `NIP_OFF_MASK
                     || PADDR == `NIP_OFF_LEVEL || PADDR == `NIP_OFF_STATUS
                     || PADDR == `NIP_OFF_ACK);
   end

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      request_flag_nxt           = request_flag_r;
      mask_flag_nxt              = mask_flag_r;
      request_level_bit_nxt      = request_level_bit_r;
      global_irq_accept_flag_nxt = global_irq_accept_flag_r;
      in_service_level_flag_nxt  = in_service_level_flag_r;
      in_trap_nxt                = in_trap_r;
      in_mask_nxt                = in_mask_r;
      gate_nxt                   = gate_r;
      hold_cnt_nxt               = hold_cnt_r;
      prdata_nxt                 = prdata_r;
      ack_valid_nxt              = 1'b0;
      ack_id_nxt                 = ack_id_r;
      ack_trap_nxt               = 1'b0;

      if (apb_rd) begin
         case (PADDR)
            `NIP_OFF_REQ:    prdata_nxt = 32'(request_flag_r);
            `NIP_OFF_MASK:   prdata_nxt = 32'(mask_flag_r);
            `NIP_OFF_LEVEL:  prdata_nxt = 32'(request_level_bit_r);
            `NIP_OFF_STATUS: prdata_nxt = 32'(STATUS);
            `NIP_OFF_ACK:    prdata_nxt = 32'({ack_trap_r, 7'h00, ack_valid_r, 8'(ack_id_r)});
            default:         prdata_nxt = 32'h00000000;
         endcase
      end
      if (apb_wr) begin
         case (PADDR)
            `NIP_OFF_REQ:   request_flag_nxt      = PWDATA[NSRC-1:0];
            `NIP_OFF_MASK:  mask_flag_nxt         = PWDATA[NSRC-1:0];
            `NIP_OFF_LEVEL: request_level_bit_nxt = PWDATA[NSRC-1:0];
            `NIP_OFF_STATUS: begin
               global_irq_accept_flag_nxt = PWDATA[`NIP_ST_ACCEPT];
               in_service_level_flag_nxt  = PWDATA[`NIP_ST_LEVEL];
            end
            default: ;
         endcase
      end

      // Sources set flags regardless of level bits; set beats a clear
      request_flag_nxt = request_flag_nxt | SRC_SET;                // [R15] [R6]

      // Hold window: deferral spans the hold op plus the next one
      if (flag_reg_hit) begin
         hold_cnt_nxt = `NIP_HOLD_DONE;                               // [R13]
      end
      if (INSTR_END) begin
         if (INSTR_CLASS == NIP_OP_HOLD) begin
            // A flag access in the same cycle keeps the longer deferral
            hold_cnt_nxt = flag_reg_hit ? `NIP_HOLD_DONE : 2'h1;      // [R12] [R13]
         end else if (hold_cnt_r != 2'h0 && !flag_reg_hit) begin
            hold_cnt_nxt = hold_cnt_r - 2'h1;
         end
         if (gate_r == NIP_GATE_WAIT) begin
            gate_nxt = NIP_GATE_OPEN;                                 // [R7]
         end
         if (OP_ENABLE) begin
            global_irq_accept_flag_nxt = 1'b1;                        // [R3]
         end
         if (OP_MASK_ALL) begin
            global_irq_accept_flag_nxt = 1'b0;
         end
         if (RESTORE_VALID) begin
            global_irq_accept_flag_nxt = RESTORE_STATUS[`NIP_ST_ACCEPT];
            in_service_level_flag_nxt  = RESTORE_STATUS[`NIP_ST_LEVEL];
         end
         if (OP_RET_IRQ || OP_RET_TRAP) begin
            gate_nxt    = NIP_GATE_WAIT;                              // [R7]
            in_trap_nxt = 1'b0;
            in_mask_nxt = 1'b0;
         end
      end

      if (INSTR_END && INSTR_CLASS == NIP_OP_TRAP) begin
         ack_trap_nxt               = 1'b1;                           // [R19] [R10]
         global_irq_accept_flag_nxt = 1'b0;                           // [R14] [R2]
         in_trap_nxt                = 1'b1;
      end else if (can_ack && !OP_RET_IRQ && !OP_RET_TRAP) begin
         ack_valid_nxt              = 1'b1;
         ack_id_nxt                 = winner[IW-1:0];
         request_flag_nxt[winner[IW-1:0]] = SRC_SET[winner[IW-1:0]];
         global_irq_accept_flag_nxt = 1'b0;                           // [R2]
         in_service_level_flag_nxt  = request_level_bit_r[winner[IW-1:0]]; // [R16]
         in_trap_nxt                = 1'b0;
         in_mask_nxt                = 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         request_flag_r           <= '0;
         mask_flag_r              <= NSRC'(`NIP_RST_MASK);
         request_level_bit_r      <= NSRC'(`NIP_RST_LEVEL);
         global_irq_accept_flag_r <= `NIP_RST_ACCEPT;
         in_service_level_flag_r  <= `NIP_RST_INLEVEL;
         in_trap_r                <= 1'b0;
         in_mask_r                <= 1'b0;
         gate_r                   <= NIP_GATE_OPEN;
         hold_cnt_r               <= 2'h0;
         prdata_r                 <= 32'h00000000;
         ack_valid_r              <= 1'b0;
         ack_id_r                 <= '0;
         ack_trap_r               <= 1'b0;
      end else begin
         request_flag_r           <= request_flag_nxt;
         mask_flag_r              <= mask_flag_nxt;
         request_level_bit_r      <= request_level_bit_nxt;
         global_irq_accept_flag_r <= global_irq_accept_flag_nxt;
         in_service_level_flag_r  <= in_service_level_flag_nxt;
         in_trap_r                <= in_trap_nxt;
         in_mask_r                <= in_mask_nxt;
         gate_r                   <= gate_nxt;
         hold_cnt_r               <= hold_cnt_nxt;
         prdata_r                 <= prdata_nxt;
         ack_valid_r              <= ack_valid_nxt;
         ack_id_r                 <= ack_id_nxt;
         ack_trap_r               <= ack_trap_nxt;
      end
   end

   always_comb begin
      PRDATA    = prdata_r;
      ACK_VALID = ack_valid_r;
      ACK_ID    = ack_id_r;
      ACK_TRAP  = ack_trap_r;
      STATUS    = {in_mask_r, in_trap_r, global_irq_accept_flag_r, in_service_level_flag_r};
   end
endmodule

// file: tb/nip_ctrl_monitor.sv
// Port assertions for the nested interrupt controller
`timescale 1ns/100ps
module nip_ctrl_monitor
   import nip_pkg::*;
(
   // Clock and reset
   input wire logic         MCLK,
   input wire logic         SRST,
   // Sequencer and acknowledge
   input wire logic         INSTR_END,
   input wire nip_opclass_t INSTR_CLASS,
   input wire logic         OP_RET_IRQ,
   input wire logic         OP_RET_TRAP,
   input wire logic         ACK_VALID,
   input wire logic         ACK_TRAP,
   input wire logic [3:0]   STATUS
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   // Marks the end after a hold end, which stays deferred too
   logic hld, gap_r, gap_nxt;
   assign hld = INSTR_END && INSTR_CLASS == NIP_OP_HOLD;
   always_comb gap_nxt = INSTR_END ? hld : gap_r;
   always_ff @(posedge MCLK) gap_r <= SRST ? 1'h0 : gap_nxt;
   property p_trap; INSTR_END && INSTR_CLASS == NIP_OP_TRAP |=> ACK_TRAP; endproperty
   a_trap: assert property (p_trap) else $error("trap missed");
   property p_trap_clr; ACK_TRAP |-> !STATUS[1]; endproperty
   a_trap_clr: assert property (p_trap_clr) else $error("trap kept accept");
   property p_no_acc; INSTR_END && !STATUS[1] |=> !ACK_VALID; endproperty
   a_no_acc: assert property (p_no_acc) else $error("ack while closed");
   property p_ack_clr; ACK_VALID |-> !STATUS[1]; endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("ack kept accept");
   property p_hold; hld |=> !ACK_VALID; endproperty
   a_hold: assert property (p_hold) else $error("ack at hold end");
   property p_gap; INSTR_END && gap_r |=> !ACK_VALID; endproperty
   a_gap: assert property (p_gap) else $error("ack after hold end");
   property p_ret; INSTR_END && (OP_RET_IRQ || OP_RET_TRAP) |=> !ACK_VALID ##1 !ACK_VALID; endproperty
   a_ret: assert property (p_ret) else $error("ack soon after return");
   property p_end; !INSTR_END |=> !ACK_VALID && !ACK_TRAP; endproperty
   a_end: assert property (p_end) else $error("ack off an end");
endmodule
bind nip_ctrl nip_ctrl_monitor u_mon (.MCLK(MCLK), .SRST(SRST), .INSTR_END(INSTR_END), .INSTR_CLASS(INSTR_CLASS),
   .OP_RET_IRQ(OP_RET_IRQ), .OP_RET_TRAP(OP_RET_TRAP), .ACK_VALID(ACK_VALID), .ACK_TRAP(ACK_TRAP), .STATUS(STATUS));

// file: tb/nip_seq_model.sv
// Behavioural instruction sequencer
`timescale 1ns/100ps
module nip_seq_model
   import nip_pkg::*;
(
   // From the bench
   input wire logic         clk,
   input wire logic         go,
   input wire nip_opclass_t cls,
   input wire logic [5:0]   op,
   // To the controller
   output logic             instr_end = 1'h0,
   output nip_opclass_t     instr_cls = NIP_OP_PLAIN,
   output logic [5:0]       instr_op = 6'h0
);
   // Qualifiers mean nothing between ends, so they carry noise there
   always @(posedge clk) begin
      instr_end <= go;
      instr_cls <= go ? cls : nip_opclass_t'($urandom % 3);
      instr_op  <= go ? op : 6'($urandom);
   end
endmodule

// file: tb/testbench.sv
// Bench with reference model and APB master
`timescale 1ns/100ps
module testbench
   import nip_pkg::*;
;
   logic         MCLK = 1'h0, SRST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, go = 1'h0;
   logic         PREADY, PSLVERR, ACK_VALID, ACK_TRAP, s_end, ok, im = 1'h0, it = 1'h0;
   logic [11:0]  PADDR = 12'h0;
   logic [31:0]  PWDATA = 32'h0, SRC_SET = 32'h0, PRDATA, pend = 32'h0, lvb, msk;
   logic [4:0]   ACK_ID;
   logic [3:0]   STATUS;
   logic [5:0]   op = 6'h0, s_op;
   nip_opclass_t cls = NIP_OP_PLAIN, s_cls;
   int           err_count = 0, n_compared = 0, acc = 0, lvf = 1, hold = 0, w, k;
   always #5 MCLK = ~MCLK;
   nip_ctrl #(.NSRC(32)) uut (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_SET(SRC_SET),
      .INSTR_END(s_end), .INSTR_CLASS(s_cls), .OP_ENABLE(s_op[0]), .OP_MASK_ALL(s_op[3]), .OP_RET_IRQ(s_op[1]),
      .OP_RET_TRAP(s_op[2]), .RESTORE_VALID(|s_op[2:1]), .RESTORE_STATUS(s_op[5:4]), .ACK_VALID(ACK_VALID),
      .ACK_ID(ACK_ID), .ACK_TRAP(ACK_TRAP), .STATUS(STATUS));
   nip_seq_model u_seq (.clk(MCLK), .go(go), .cls(cls), .op(op), .instr_end(s_end), .instr_cls(s_cls),
      .instr_op(s_op));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] x);
      {PSEL, PWRITE, PADDR, PWDATA} <= {1'h1, wr, a, x};
      @(posedge MCLK);
      PENABLE <= 1'h1;
      do @(posedge MCLK); while (PREADY !== 1'h1);
      cmp(PSLVERR, a > 12'h010);
      if (!wr) cmp(PRDATA, a > 12'h010 ? 32'h0 : x);
      {PSEL, PENABLE} <= 2'h0;
      @(posedge MCLK);
   endtask
   task automatic raise(input int s);
      SRC_SET <= 32'h1 << s;
      pend[s] = 1'h1;
      @(posedge MCLK);
      SRC_SET <= 32'h0;
      @(posedge MCLK);
   endtask
   // One instruction end; the model decides before the end's own ops apply
   task automatic instr(input nip_opclass_t c, input logic [5:0] o);
      cls <= c;
      {op, go} <= {o, 1'h1};
      @(posedge MCLK);
      go <= 1'h0;
      w = -1;
      for (int i = 31; i >= 0; i--)
         if (pend[i] && !msk[i] && (w < 0 || lvb[i] <= lvb[w])) w = i;
      ok = c == NIP_OP_PLAIN && acc && !hold && w >= 0 && (lvf || it || !lvb[w]);
      if (ok) pend[w] = 1'h0;
      if (ok) lvf = lvb[w];
      if (ok || c == NIP_OP_TRAP || o[3]) acc = 0;
      if (o[0]) acc = 1;
      if (o[1] || o[2]) acc = o[5];
      if (o[1] || o[2]) lvf = o[4];
      if (o[1] || o[2]) {im, it} = 2'h0;
      if (ok) {im, it} = 2'h2;
      if (c == NIP_OP_TRAP) it = 1'h1;
      hold = c == NIP_OP_HOLD;
      @(posedge MCLK);
      #1;
      cmp(ACK_VALID, ok);
      if (ok) cmp(ACK_ID, w);
      cmp(ACK_TRAP, c == NIP_OP_TRAP);
      cmp(STATUS, {im, it, acc[0], lvf[0]});
      @(posedge MCLK);
   endtask
   initial begin
      #100000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      k = $urandom(32'h1E5C);
      msk = 32'hFFFF0000;
      lvb = ($urandom & 32'hFFFFFFFB) | 32'h200;
      repeat (8) @(posedge MCLK);
      cmp(STATUS, 4'h1);
      SRST <= 1'h0;
      @(posedge MCLK);
      bus(1'h0, 12'h000, 32'h0);
      bus(1'h0, 12'h004, 32'hFFFFFFFF);
      bus(1'h0, 12'h040, 32'h0);
      bus(1'h1, 12'h004, msk);
      bus(1'h1, 12'h008, lvb);
      bus(1'h0, 12'h008, lvb);
      bus(1'h1, 12'h00C, 32'h3);
      acc = 1;
      repeat (2) instr(NIP_OP_HOLD, 6'h0);
      raise(9);
      raise(2);
      instr(NIP_OP_PLAIN, 6'h0);
      instr(NIP_OP_PLAIN, 6'h0);
      instr(NIP_OP_HOLD, 6'h1);
      repeat (2) instr(NIP_OP_PLAIN, 6'h0);
      raise(20);
      instr(NIP_OP_HOLD, 6'h32);
      repeat (2) instr(NIP_OP_PLAIN, 6'h0);
      bus(1'h0, 12'h000, pend);
      repeat (2) instr(NIP_OP_HOLD, 6'h0);
      repeat (60) begin
         if ($urandom % 2) raise($urandom % 32);
         k = $urandom % 6;
         instr(k < 4 ? NIP_OP_HOLD : NIP_OP_PLAIN, {2'($urandom), k == 3, 1'h0, k == 2, k == 1});
      end
      // Trap routine with level flag 0 must still nest a low-level request
      bus(1'h1, 12'h00C, 32'h0);
      acc = 0;
      lvf = 0;
      bus(1'h1, 12'h000, 32'h0);
      pend = 32'h0;
      raise(9);
      instr(NIP_OP_TRAP, 6'h0);
      instr(NIP_OP_HOLD, 6'h1);
      repeat (2) instr(NIP_OP_PLAIN, 6'h0);
      bus(1'h0, 12'h010, 32'h9);
      instr(NIP_OP_HOLD, 6'h4);
      tally_and_finish();
   end
endmodule
